/* File: verilog/xor_exec_consts.vh */
// Constants for the exclusive-OR execute block
`ifndef XOR_EXEC_CONSTS_VH
`define XOR_EXEC_CONSTS_VH
`define IMM_OPC 8'h0A
`define FILE_OPC 6'h06
`define DEST_BIT 9
`define BANK_BIT 8
`define IDX_LIMIT 8'h5F
`define ACCESS_SPLIT 8'h60
`define ACC_RST 8'h00
`define BANK_RST 6'h00
`define PH_DECODE 2'h0
`define PH_READ 2'h1
`define PH_PROC 2'h2
`define PH_WRITE 2'h3
`endif

/* File: verilog/xor_instruction_execute.v */
// Decode and execute of the two exclusive-OR instructions
// Notes on behaviour
// - Immediate form XORs accumulator with 8-bit literal, result to accumulator, sets N,Z.
// - Immediate form has upper byte 0000 1010; low byte is the literal.
// - File form has upper six bits 0001 10, then destination, bank, 8-bit address.
// - Destination clear: result to accumulator, register untouched, N and Z updated.
// - Destination set: result written back to the addressed register.
// - Bank bit clear selects access bank; set uses bank pointer as upper bits.
// - Extended set, bank bit clear, address up to 5Fh: indexed literal offset.
`include "xor_exec_consts.vh"
module xor_instruction_execute #(
   parameter AW = 14
) (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire instr_valid,
   input wire [15:0] instr_word,
   input wire ext_set_en,
   input wire [AW-9:0] bank_pointer_reg,
   input wire [AW-1:0] index_base,
   input wire [7:0] mem_rdata,
   output reg [AW-1:0] mem_addr_ff,
   output reg mem_rd_ff,
   output reg mem_we_ff,
   output reg [7:0] mem_wdata_ff,
   output reg [7:0] acc_ff,
   output reg neg_flag_ff,
   output reg zero_flag_ff,
   output reg [1:0] phase_ff,
   output reg busy_ff,
   output reg done_ff
);
   // Instruction state
   reg is_imm_ff;
   reg dest_ff;
   reg [7:0] operand_ff;
   reg [7:0] result_ff;
   reg [15:0] word_ff;

   // Next values
   reg [1:0] nxt_phase;
   reg nxt_busy;
   reg nxt_done;
   reg nxt_is_imm;
   reg nxt_dest;
   reg [7:0] nxt_operand;
   reg [7:0] nxt_result;
   reg [15:0] nxt_word;
   reg [AW-1:0] nxt_mem_addr;
   reg nxt_mem_rd;
   reg nxt_mem_we;
   reg [7:0] nxt_mem_wdata;
   reg [7:0] nxt_acc;
   reg nxt_neg;
   reg nxt_zero;

   // Decode and addressing
   wire is_imm;
   wire is_file;
   wire take;
   wire [7:0] faddr;
   wire abit;
   wire use_index;
   reg [AW-1:0] eff_addr;

   ////////////////////////////////////////////////////////////////////////////
   // Shared arithmetic

   // Exclusive-OR of the accumulator with the selected operand
   function [7:0] xor_byte;
      input [7:0] acc;
      input [7:0] opd;
      begin
         xor_byte = acc ^ opd;
      end
   endfunction

   // Sign of a result
   function neg_of;
      input [7:0] res;
      begin
         neg_of = res[7];
      end
   endfunction

   // Zero test of a result
   function zero_of;
      input [7:0] res;
      begin
         zero_of = (res == 8'h00);
      end
   endfunction

   // Access bank: low offsets at the bottom of memory, the rest at the top
   function [AW-1:0] access_addr;
      input [7:0] f;
      begin
         if (f < `ACCESS_SPLIT) begin
            access_addr = {{(AW-8){1'h0}}, f};
         end else begin
            access_addr = {{(AW-8){1'h1}}, f};
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   assign is_imm = (instr_word[15:8] == `IMM_OPC);
   assign is_file = (instr_word[15:10] == `FILE_OPC);
   assign take = instr_valid && (is_imm || is_file);
   assign faddr = word_ff[7:0];
   assign abit = word_ff[`BANK_BIT];
   assign use_index = !abit && ext_set_en && (faddr <= `IDX_LIMIT);

   ////////////////////////////////////////////////////////////////////////////
   // Data address of the file form, from the latched word

   always @* begin
      eff_addr = {AW{1'h0}};
      if (use_index) begin
         eff_addr = index_base + {{(AW-8){1'h0}}, faddr};
      end else if (abit) begin
         eff_addr = {bank_pointer_reg, faddr};
      end else begin
         eff_addr = access_addr(faddr);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state of the four phase sequence

   always @* begin
      nxt_phase = phase_ff;
      nxt_busy = busy_ff;
      nxt_done = 1'h0;
      nxt_is_imm = is_imm_ff;
      nxt_dest = dest_ff;
      nxt_operand = operand_ff;
      nxt_result = result_ff;
      nxt_word = word_ff;
      nxt_mem_addr = mem_addr_ff;
      nxt_mem_rd = 1'h0;
      nxt_mem_we = 1'h0;
      nxt_mem_wdata = mem_wdata_ff;
      nxt_acc = acc_ff;
      nxt_neg = neg_flag_ff;
      nxt_zero = zero_flag_ff;
      case (phase_ff)
         `PH_DECODE: begin
            // Words that match neither form are ignored
            if (take) begin
               nxt_word = instr_word;
               nxt_is_imm = is_imm;
               nxt_dest = instr_word[`DEST_BIT];
               nxt_busy = 1'h1;
               nxt_phase = `PH_READ;
            end
         end
         `PH_READ: begin
            if (is_imm_ff) begin
               nxt_operand = word_ff[7:0];
            end else begin
               nxt_mem_addr = eff_addr;
               nxt_mem_rd = 1'h1;
            end
            nxt_phase = `PH_PROC;
         end
         `PH_PROC: begin
            if (is_imm_ff) begin
               nxt_result = xor_byte(acc_ff, operand_ff);
            end else begin
               // Read data is valid while the read strobe stands
               nxt_result = xor_byte(acc_ff, mem_rdata);
            end
            nxt_phase = `PH_WRITE;
         end
         `PH_WRITE: begin
            if (!is_imm_ff && dest_ff) begin
               nxt_mem_we = 1'h1;
               nxt_mem_wdata = result_ff;
            end else begin
               nxt_acc = result_ff;
            end
            nxt_neg = neg_of(result_ff);
            nxt_zero = zero_of(result_ff);
            nxt_busy = 1'h0;
            nxt_done = 1'h1;
            nxt_phase = `PH_DECODE;
         end
         default: begin
            nxt_phase = `PH_DECODE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers, all held while the clock enable is low

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_ff <= `PH_DECODE;
         busy_ff <= 1'h0;
         done_ff <= 1'h0;
         is_imm_ff <= 1'h0;
         dest_ff <= 1'h0;
         word_ff <= 16'h0000;
         operand_ff <= 8'h00;
         result_ff <= 8'h00;
         mem_addr_ff <= {AW{1'h0}};
         mem_rd_ff <= 1'h0;
         mem_we_ff <= 1'h0;
         mem_wdata_ff <= 8'h00;
         acc_ff <= `ACC_RST;
         neg_flag_ff <= 1'h0;
         zero_flag_ff <= 1'h0;
      end else if (ce) begin
         phase_ff <= nxt_phase;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
         is_imm_ff <= nxt_is_imm;
         dest_ff <= nxt_dest;
         word_ff <= nxt_word;
         operand_ff <= nxt_operand;
         result_ff <= nxt_result;
         mem_addr_ff <= nxt_mem_addr;
         mem_rd_ff <= nxt_mem_rd;
         mem_we_ff <= nxt_mem_we;
         mem_wdata_ff <= nxt_mem_wdata;
         acc_ff <= nxt_acc;
         neg_flag_ff <= nxt_neg;
         zero_flag_ff <= nxt_zero;
      end
   end
endmodule // xor_instruction_execute

/* File: verification/xor_exec_props.sv */
// Timing and result properties of the exclusive-OR execute block
module xor_exec_props #(parameter AW = 14) (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire instr_valid,
   input wire [15:0] instr_word,
   input wire mem_rd_ff,
   input wire mem_we_ff,
   input wire [7:0] acc_ff,
   input wire neg_flag_ff,
   input wire zero_flag_ff,
   input wire [1:0] phase_ff,
   input wire busy_ff,
   input wire done_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_take; ce && phase_ff == 2'h0 && instr_valid &&
      (instr_word[15:8] == 8'h0A || instr_word[15:10] == 6'h06); endsequence
   sequence s_imm; s_take ##0 instr_word[15:8] == 8'h0A; endsequence
   sequence s_file; s_take ##0 instr_word[15:10] == 6'h06; endsequence
   sequence s_steps; phase_ff == 2'h1 ##1 phase_ff == 2'h2 ##1 phase_ff == 2'h3; endsequence
   property p_phase; s_take |=> s_steps ##1 phase_ff == 2'h0; endproperty
   a_phase: assert property (p_phase) else $error("phase order");
   property p_busy; s_take |=> busy_ff [*3] ##1 !busy_ff; endproperty
   a_busy: assert property (p_busy) else $error("busy span");
   property p_done; s_take ##1 ce [*3] |=> done_ff; endproperty
   a_done: assert property (p_done) else $error("done late");
   property p_rd; s_file |-> ##2 mem_rd_ff; endproperty
   a_rd: assert property (p_rd) else $error("no read");
   property p_nord; s_imm |-> ##1 !mem_rd_ff [*3]; endproperty
   a_nord: assert property (p_nord) else $error("stray read");
   property p_we; mem_we_ff |-> done_ff && $stable(acc_ff); endproperty
   a_we: assert property (p_we) else $error("write side");
   property p_d0; s_file ##0 !instr_word[9] |-> ##1 !mem_we_ff [*4]; endproperty
   a_d0: assert property (p_d0) else $error("stray write");
   property p_acc; logic [7:0] v;
      (s_imm, v = acc_ff ^ instr_word[7:0]) |-> ##4 acc_ff == v && zero_flag_ff == (v == 8'h00)
      && neg_flag_ff == v[7]; endproperty
   a_acc: assert property (p_acc) else $error("bad result");
   property p_freeze; !ce |=> $stable(phase_ff) && $stable(busy_ff) && $stable(acc_ff); endproperty
   a_freeze: assert property (p_freeze) else $error("moved while held");
endmodule // xor_exec_props
bind xor_instruction_execute xor_exec_props #(.AW(AW)) u_props (.*);

/* File: verification/xor_instruction_execute_bench.sv */
// Self-checking bench for the exclusive-OR execute block
module xor_instruction_execute_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0, rst = 1'h1, ce = 1'h1, instr_valid = 1'h0, ext_set_en = 1'h0;
   logic [15:0] instr_word = 16'h0000;
   logic [5:0] bank_pointer_reg = 6'h00;
   logic [13:0] index_base = 14'h0100, mem_addr_ff;
   logic [7:0] mem_rdata = 8'h00, mem_wdata_ff, acc_ff;
   logic mem_rd_ff, mem_we_ff, neg_flag_ff, zero_flag_ff, busy_ff, done_ff;
   logic [1:0] phase_ff;
   int mismatches = 0, n_tests = 0;
   xor_instruction_execute dut (.*);
   always #5 clk = ~clk;
   task end_of_test;
      $display("mismatches %0d of %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input [15:0] g, input [15:0] e);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: %h not %h", $time, g, e);
      end
   endtask
   // Offers one word at a rising edge, looks mid-cycle after the write phase
   task run(input [15:0] w, input [7:0] d);
      @(posedge clk);
      instr_word <= w;
      mem_rdata <= d;
      instr_valid <= 1'h1;
      @(posedge clk);
      instr_valid <= 1'h0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(done_ff, 16'h0001);
   endtask
   // Clock enable low holds decode; near-miss opcodes are ignored
   task t_hold;
      @(posedge clk);
      ce <= 1'h0;
      instr_word <= 16'h0A0F;
      instr_valid <= 1'h1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({busy_ff, phase_ff}, 16'h0000);
      @(posedge clk);
      ce <= 1'h1;
      instr_word <= 16'h0B55;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({busy_ff, acc_ff}, 16'h0000);
      @(posedge clk);
      instr_word <= 16'h1C55;
      repeat (2) @(posedge clk);
      instr_valid <= 1'h0;
      @(negedge clk);
      chk({busy_ff, acc_ff}, 16'h0000);
   endtask
   task t_imm;
      run(16'h0AB5, 8'h00);
      chk({neg_flag_ff, zero_flag_ff}, 16'h0002);
      run(16'h0AAF, 8'h00);
      chk(acc_ff, 16'h001A);
      run(16'h0A1A, 8'h00);
      chk({neg_flag_ff, zero_flag_ff}, 16'h0001);
   endtask
   task t_file;
      @(posedge clk);
      bank_pointer_reg <= 6'h05;
      run(16'h1870, 8'h9A);
      chk({acc_ff, mem_addr_ff[7:0]}, 16'h9A70);
      chk({mem_we_ff, neg_flag_ff, zero_flag_ff}, 16'h0002);
      chk(mem_addr_ff, 16'h3F70);
      run(16'h1B40, 8'h0F);
      chk({mem_we_ff, mem_wdata_ff}, 16'h0195);
      chk(acc_ff, 16'h009A);
      chk(mem_addr_ff, 16'h0540);
      run(16'h1830, 8'h9A);
      chk(mem_addr_ff, 16'h0030);
      chk({acc_ff, neg_flag_ff, zero_flag_ff}, 16'h0001);
   endtask
   task t_idx;
      @(posedge clk);
      ext_set_en <= 1'h1;
      run(16'h185F, 8'h00);
      chk(mem_addr_ff, 16'h015F);
      run(16'h1A60, 8'h00);
      chk(mem_addr_ff, 16'h3F60);
      run(16'h195F, 8'h3C);
      chk(mem_addr_ff, 16'h055F);
      chk(acc_ff, 16'h003C);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      t_hold;
      t_imm;
      t_file;
      t_idx;
      end_of_test;
   end
   // Watchdog at about four times the length of a clean run
   initial begin
      #3000;
      mismatches++;
      end_of_test;
   end
endmodule // xor_instruction_execute_bench
